/* File: verilog/adc_regs_pkg.sv */
// constants for the converter status, input select and gain registers
package adc_regs_pkg;
  // register addresses
  localparam logic [7:0] ADDR_DEVICE_STATUS = 8'h01;
  localparam logic [7:0] ADDR_INPUT_SELECT = 8'h02;
  localparam logic [7:0] ADDR_AMPLIFIER_GAIN = 8'h03;
  // reset values
  localparam logic [7:0] RST_DEVICE_STATUS = 8'h80;
  localparam logic [7:0] RST_INPUT_SELECT = 8'h01;
  localparam logic [7:0] RST_AMPLIFIER_GAIN = 8'h00;
  // status field positions
  localparam int POS_POWER_ON_FLAG = 7;
  localparam int POS_NOT_READY = 6;
  localparam int POS_REF_LOW = 0;
  // input select fields
  localparam int POS_PSEL_HI = 7;
  localparam int POS_PSEL_LO = 4;
  localparam int POS_NSEL_HI = 3;
  localparam int POS_NSEL_LO = 0;
  // amplifier fields
  localparam int POS_AMP_EN_HI = 4;
  localparam int POS_AMP_EN_LO = 3;
  localparam int POS_GAIN_HI = 2;
  localparam int POS_GAIN_LO = 0;
  // input select codes
  localparam logic [3:0] SEL_LAST_ANALOG = 4'hb;
  localparam logic [3:0] SEL_LAST_SMALL = 4'h5;
  localparam logic [3:0] SEL_COMMON = 4'hc;
  // amplifier enable codes
  localparam logic [1:0] AMP_BYPASS = 2'h0;
  localparam logic [1:0] AMP_ENABLED = 2'h1;
  // command opcodes, upper three bits
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
endpackage

/* File: verilog/adc_status_mux_gain_registers.sv */
// status, input select and amplifier gain registers behind the serial port
`timescale 1ns/1ns
module adc_status_mux_gain_registers #(
  parameter bit TWELVE_CHANNEL = 1'b1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe_n,
  input wire logic i_ready,
  input wire logic i_ref_below_limit,
  input wire logic i_reference_monitor_enable,
  output logic [3:0] o_positive_input_select,
  output logic [3:0] o_negative_input_select,
  output logic o_positive_select_valid,
  output logic o_negative_select_valid,
  output logic o_amplifier_enabled,
  output logic [7:0] o_amplifier_gain,
  output logic o_amplifier_config_valid
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] cs_sync;
  logic [1:0] sclk_sync;
  logic [1:0] din_sync;
  logic [1:0] rdy_sync;
  logic [1:0] ref_sync;
  logic [1:0] mon_sync;
  logic sclk_prev;
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      cs_sync <= 2'h3;
      sclk_sync <= 2'h0;
      din_sync <= 2'h0;
      rdy_sync <= 2'h0;
      ref_sync <= 2'h0;
      mon_sync <= 2'h0;
      sclk_prev <= 1'b0;
    end
    else
    begin
      cs_sync <= {cs_sync[0], i_cs_n};
      sclk_sync <= {sclk_sync[0], i_sclk};
      din_sync <= {din_sync[0], i_din};
      rdy_sync <= {rdy_sync[0], i_ready};
      ref_sync <= {ref_sync[0], i_ref_below_limit};
      mon_sync <= {mon_sync[0], i_reference_monitor_enable};
      sclk_prev <= sclk_sync[1];
    end
  end

  wire cs_active = !cs_sync[1];
  wire sclk_rise = cs_active && sclk_sync[1] && !sclk_prev;
  wire sclk_fall = cs_active && !sclk_sync[1] && sclk_prev;

  // ---------------------------------------------------------------
  // selector decoding
  // ---------------------------------------------------------------
  function automatic logic sel_valid(input logic [3:0] code);
    logic [3:0] last;
    last = TWELVE_CHANNEL ? adc_regs_pkg::SEL_LAST_ANALOG : adc_regs_pkg::SEL_LAST_SMALL;
    sel_valid = (code <= last) || (code == adc_regs_pkg::SEL_COMMON);
  endfunction

  // ---------------------------------------------------------------
  // serial command engine
  // ---------------------------------------------------------------
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [2:0] bit_cnt;
  logic [4:0] cur_addr;
  logic [4:0] remaining;
  typedef enum logic [1:0] {PH_COMMAND, PH_COUNT, PH_DATA, PH_IGNORE} frame_phase_e;
  frame_phase_e phase;
  logic is_write;
  logic power_on_event_flag;
  logic [7:0] input_select;
  logic [7:0] amplifier_gain_setting;
  logic reference_low_flag;

  wire [7:0] shifted = {shift_in[6:0], din_sync[1]};
  wire byte_done = sclk_rise && (bit_cnt == 3'h7);
  wire data_byte = byte_done && (phase == PH_DATA);
  wire do_write = data_byte && is_write;
  wire wr_status = do_write && (cur_addr == adc_regs_pkg::ADDR_DEVICE_STATUS[4:0]);
  wire wr_mux = do_write && (cur_addr == adc_regs_pkg::ADDR_INPUT_SELECT[4:0]);
  wire wr_amp = do_write && (cur_addr == adc_regs_pkg::ADDR_AMPLIFIER_GAIN[4:0]);
  wire [4:0] next_addr = (phase == PH_DATA && byte_done) ? cur_addr + 5'h1
    : (phase == PH_COMMAND && byte_done) ? shifted[4:0] : cur_addr;
  // no reload once the counted bytes are spent
  wire load_read = byte_done && !is_write
    && (phase == PH_COUNT || (phase == PH_DATA && remaining != 5'h0));

  wire [7:0] status_view = {power_on_event_flag, rdy_sync[1], 5'h00, reference_low_flag};
  wire [7:0] amp_view = {3'h0, amplifier_gain_setting[4:0]};
  wire [7:0] read_data =
    (next_addr == adc_regs_pkg::ADDR_DEVICE_STATUS[4:0]) ? status_view :
    (next_addr == adc_regs_pkg::ADDR_INPUT_SELECT[4:0]) ? input_select :
    (next_addr == adc_regs_pkg::ADDR_AMPLIFIER_GAIN[4:0]) ? amp_view : 8'h00;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || !cs_active)
    begin
      shift_in <= 8'h00;
      bit_cnt <= 3'h0;
      phase <= PH_COMMAND;
      is_write <= 1'b0;
      cur_addr <= 5'h00;
      remaining <= 5'h00;
    end
    else if (sclk_rise)
    begin
      shift_in <= shifted;
      bit_cnt <= bit_cnt + 3'h1;
      cur_addr <= next_addr;
      if (byte_done)
      begin
        unique case (phase)
          PH_COMMAND:
          begin
            is_write <= (shifted[7:5] == adc_regs_pkg::OP_WRITE);
            phase <= (shifted[7:5] == adc_regs_pkg::OP_WRITE
              || shifted[7:5] == adc_regs_pkg::OP_READ) ? PH_COUNT : PH_IGNORE;
          end
          PH_COUNT:
          begin
            remaining <= shifted[4:0];
            phase <= PH_DATA;
          end
          PH_DATA:
          begin
            remaining <= remaining - 5'h1;
            if (remaining == 5'h0)
              phase <= PH_IGNORE;
          end
          PH_IGNORE:
            phase <= PH_IGNORE;
        endcase
      end
    end
  end

  // output shifter, loads on the rising clock edge that ends a byte, shifts on falling clock edges except the last of each byte
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || !cs_active)
      shift_out <= 8'h00;
    else if (load_read)
      shift_out <= read_data;
    else if (sclk_fall && bit_cnt != 3'h0)
      shift_out <= {shift_out[6:0], 1'b0};
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      power_on_event_flag <= adc_regs_pkg::RST_DEVICE_STATUS[adc_regs_pkg::POS_POWER_ON_FLAG];
      input_select <= adc_regs_pkg::RST_INPUT_SELECT;
      amplifier_gain_setting <= adc_regs_pkg::RST_AMPLIFIER_GAIN;
      reference_low_flag <= 1'b0;
    end
    else
    begin
      if (wr_status && !shifted[adc_regs_pkg::POS_POWER_ON_FLAG])
        power_on_event_flag <= 1'b0;
      if (wr_mux)
        input_select <= shifted;
      if (wr_amp)
        amplifier_gain_setting <= {3'h0, shifted[4:0]};
      reference_low_flag <= mon_sync[1] && ref_sync[1];
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic [2:0] gain_code;
  logic [1:0] amp_en;
  assign gain_code = amplifier_gain_setting[adc_regs_pkg::POS_GAIN_HI:adc_regs_pkg::POS_GAIN_LO];
  assign amp_en = amplifier_gain_setting[adc_regs_pkg::POS_AMP_EN_HI:adc_regs_pkg::POS_AMP_EN_LO];

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_dout <= 1'b0;
      o_dout_oe_n <= 1'b1;
      o_positive_input_select <= 4'h0;
      o_negative_input_select <= 4'h1;
      o_positive_select_valid <= 1'b1;
      o_negative_select_valid <= 1'b1;
      o_amplifier_enabled <= 1'b0;
      o_amplifier_gain <= 8'h01;
      o_amplifier_config_valid <= 1'b1;
    end
    else
    begin
      o_dout <= shift_out[7];
      o_dout_oe_n <= !cs_active;
      o_positive_input_select <= input_select[adc_regs_pkg::POS_PSEL_HI:adc_regs_pkg::POS_PSEL_LO];
      o_positive_select_valid <=
        sel_valid(input_select[adc_regs_pkg::POS_PSEL_HI:adc_regs_pkg::POS_PSEL_LO]);
      o_negative_input_select <= input_select[adc_regs_pkg::POS_NSEL_HI:adc_regs_pkg::POS_NSEL_LO];
      o_negative_select_valid <=
        sel_valid(input_select[adc_regs_pkg::POS_NSEL_HI:adc_regs_pkg::POS_NSEL_LO]);
      o_amplifier_enabled <= (amp_en == adc_regs_pkg::AMP_ENABLED);
      o_amplifier_config_valid <= (amp_en == adc_regs_pkg::AMP_BYPASS)
        || (amp_en == adc_regs_pkg::AMP_ENABLED);
      o_amplifier_gain <= 8'h01 << gain_code;
    end
  end
endmodule

/* File: bench/adc_regs_props.sv */
// assertions on the register block ports
`timescale 1ns/1ns
module adc_regs_props #(
  parameter bit TWELVE_CHANNEL = 1'b1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_din,
  input wire logic o_dout,
  input wire logic o_dout_oe_n,
  input wire logic i_ready,
  input wire logic i_ref_below_limit,
  input wire logic i_reference_monitor_enable,
  input wire logic [3:0] o_positive_input_select,
  input wire logic [3:0] o_negative_input_select,
  input wire logic o_positive_select_valid,
  input wire logic o_negative_select_valid,
  input wire logic o_amplifier_enabled,
  input wire logic [7:0] o_amplifier_gain,
  input wire logic o_amplifier_config_valid
);
  wire logic [3:0] last_sel = TWELVE_CHANNEL ? adc_regs_pkg::SEL_LAST_ANALOG
    : adc_regs_pkg::SEL_LAST_SMALL;
  default clocking dc @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // ----
  // port checks
  // ----
  sequence idle_s;
    i_cs_n [*4];
  endsequence
  sequence active_s;
    !i_cs_n [*4];
  endsequence
  oe_idle_a: assert property (idle_s |-> o_dout_oe_n)
    else $error("data pin driven outside frame");
  oe_active_a: assert property (active_s |-> !o_dout_oe_n)
    else $error("data pin released inside frame");
  mux_hold_a: assert property (idle_s |=> $stable(o_positive_input_select)
    && $stable(o_negative_input_select)) else $error("input select moved while idle");
  amp_hold_a: assert property (idle_s |=> $stable(o_amplifier_gain)
    && $stable(o_amplifier_enabled)) else $error("amplifier moved while idle");
  pos_code_a: assert property (o_positive_select_valid ==
    (o_positive_input_select <= last_sel || o_positive_input_select == adc_regs_pkg::SEL_COMMON))
    else $error("positive valid wrong");
  neg_code_a: assert property (o_negative_select_valid ==
    (o_negative_input_select <= last_sel || o_negative_input_select == adc_regs_pkg::SEL_COMMON))
    else $error("negative valid wrong");
  amp_code_a: assert property (o_amplifier_enabled |-> o_amplifier_config_valid)
    else $error("enabled with reserved code");
  gain_map_a: assert property ($onehot(o_amplifier_gain))
    else $error("gain not a power of two");
  reset_val_a: assert property ($rose(i_rst_n) |-> o_negative_input_select == 4'h1
    && o_positive_input_select == 4'h0 && o_amplifier_gain == 8'h01 && !o_amplifier_enabled)
    else $error("reset values wrong");
endmodule
bind adc_status_mux_gain_registers adc_regs_props #(.TWELVE_CHANNEL(TWELVE_CHANNEL)) u_props (.*);

/* File: bench/host_spi_model.sv */
// serial host model issuing register commands
`timescale 1ns/1ns
module host_spi_model (
  input wire logic i_ref_clk,
  input wire logic i_dout,
  input wire logic i_dout_oe_n,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din
);
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din = 1'b0;
  end
  task automatic tick(int n);
    repeat (n) @(posedge i_ref_clk);
    #5;
  endtask
  task automatic frame(input logic [2:0] op, input logic [4:0] adr, input logic [7:0] wd,
      output logic [7:0] rd);
    logic [23:0] sh;
    sh = {op, adr, 8'h00, wd};
    rd = 8'h00;
    tick(1);
    o_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      o_din = sh[i];
      tick(5);
      o_sclk = 1'b1;
      tick(4);
      if (i < 8)
        // released pin reads as the inverse
        rd[i] = i_dout_oe_n ? ~i_dout : i_dout;
      tick(1);
      o_sclk = 1'b0;
    end
    tick(5);
    o_cs_n = 1'b1;
    o_din = ~o_din;
    tick(5);
  endtask
endmodule

/* File: bench/tb_top.sv */
// testbench for the status, input select and gain registers
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rdy = 1'b0, low = 1'b0, men = 1'b0;
  logic cs_n, sclk, din, dout, oe_n, pv, nv, aen, acv;
  logic [3:0] psel, nsel;
  logic [7:0] gain, rd, w;
  int errors = 0, check_count = 0, cycles = 0, por = 1, mux = 1, amp = 0;
  int seed = 32'h7b1044d6;
  always #25 clk = ~clk;
  adc_status_mux_gain_registers u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n),
    .i_sclk(sclk), .i_din(din), .o_dout(dout), .o_dout_oe_n(oe_n), .i_ready(rdy),
    .i_ref_below_limit(low), .i_reference_monitor_enable(men),
    .o_positive_input_select(psel), .o_negative_input_select(nsel),
    .o_positive_select_valid(pv), .o_negative_select_valid(nv), .o_amplifier_enabled(aen),
    .o_amplifier_gain(gain), .o_amplifier_config_valid(acv));
  host_spi_model u_host (.i_ref_clk(clk), .i_dout(dout), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_din(din), .i_dout_oe_n(oe_n));
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      report_and_stop();
    end
  end
  task automatic rd_chk(logic [4:0] a, int exp);
    u_host.frame(3'h1, a, 8'h00, rd);
    chk("register", rd, exp[7:0]);
  endtask
  task automatic chk_out();
    int p, n, e;
    p = mux >> 4;
    n = mux & 15;
    e = (amp >> 3) & 3;
    chk("pos", {4'h0, psel}, p[7:0]);
    chk("pos valid", {7'h0, pv}, {7'h0, p <= 12});
    chk("neg", {4'h0, nsel}, n[7:0]);
    chk("neg valid", {7'h0, nv}, {7'h0, n <= 12});
    chk("amp on", {7'h0, aen}, {7'h0, e == 1});
    chk("amp valid", {7'h0, acv}, {7'h0, e <= 1});
    chk("gain", gain, 8'h01 << (amp & 7));
  endtask
  task automatic reset_and_check();
    rst_n = 1'b0;
    {men, low, rdy} = 3'h0;
    por = 1;
    mux = 1;
    amp = 0;
    repeat (10) @(posedge clk);
    #5 rst_n = 1'b1;
    repeat (5) @(posedge clk);
    #5;
    chk_out();
    rd_chk(5'h01, por * 128);
    rd_chk(5'h02, mux);
    rd_chk(5'h03, amp);
  endtask
  initial
  begin
    reset_and_check();
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      {men, low, rdy} = i[2:0];
      u_host.frame(3'h2, 5'h01, {i < 4, 7'h7f}, rd);
      por = (i < 4) ? por : 0;
      rd_chk(5'h01, por * 128 + i[0] * 64 + (i[2] & i[1]));
    end
    $display("test status done");
    for (int i = 0; i < 16; i++)
    begin
      w = $random(seed);
      mux = {i[3:0], w[3:0]};
      u_host.frame(3'h2, 5'h02, mux[7:0], rd);
      w = {w[7:5], i[1:0], (i[1:0] == 2'h0) ? 3'h0 : i[3:1]};
      u_host.frame(3'h2, 5'h03, w, rd);
      amp = w & 8'h1f;
      chk_out();
      rd_chk(5'h02, mux);
      rd_chk(5'h03, amp);
    end
    $display("test select and gain done");
    u_host.frame(3'h5, 5'h02, 8'h00, rd);
    u_host.frame(3'h2, 5'h07, 8'hff, rd);
    rd_chk(5'h07, 0);
    rd_chk(5'h02, mux);
    $display("test refusal done");
    reset_and_check();
    $display("test second reset done");
    report_and_stop();
  end
endmodule
